// *** logic/ssds_pkg.sv ***
// shared constants and carriers for the safety switch diagnostic supervisor
package ssds_pkg;
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned WARN_MIN     = 30;
  localparam longint unsigned WARN_CYC = 64'(WARN_MIN) * 64'(60) * 64'(CLK_HZ);
  localparam int unsigned FLASH_HZ     = 1;
  localparam int unsigned HALF_1HZ_CYC = CLK_HZ / (2 * FLASH_HZ);
  localparam int unsigned PULSE_MS     = 200;
  localparam int unsigned PULSE_CYC    = (CLK_HZ / 1000) * PULSE_MS;
  localparam int unsigned PAUSE_PULSES = 5;
  localparam int unsigned CHAIN_MAX    = 31;

  // request byte
  localparam int unsigned REQ_RESET_BIT = 7;
  // response byte
  localparam int unsigned RSP_OUT_ACT = 0;
  localparam int unsigned RSP_ACT_DET = 1;
  localparam int unsigned RSP_INPUTS  = 4;
  localparam int unsigned RSP_CODING  = 5;
  localparam int unsigned RSP_WARN    = 6;
  localparam int unsigned RSP_ERROR   = 7;
  // detail bytes
  localparam int unsigned DET_OUT_A  = 0;
  localparam int unsigned DET_OUT_B  = 1;
  localparam int unsigned DET_CROSS  = 2;
  localparam int unsigned DET_TEMP   = 3;
  localparam int unsigned DET_ACT    = 4;
  localparam int unsigned DET_INT    = 5;
  localparam int unsigned DET_COMM   = 6;
  localparam int unsigned DET_HANDLE = 7;

  // flash pulse counts
  localparam logic [2:0] CODE_NONE   = 3'h0;
  localparam logic [2:0] CODE_OUT_A  = 3'h1;
  localparam logic [2:0] CODE_OUT_B  = 3'h2;
  localparam logic [2:0] CODE_CROSS  = 3'h3;
  localparam logic [2:0] CODE_TEMP   = 3'h4;
  localparam logic [2:0] CODE_ACT    = 3'h5;
  localparam logic [2:0] CODE_HANDLE = 3'h6;

  typedef struct packed {
    logic out_a_test_fail;
    logic out_a_volt_off;
    logic out_b_test_fail;
    logic out_b_volt_off;
    logic cross_short;
    logic over_temp;
    logic actuator_fault;
    logic handle_fault;
    logic internal_fault;
  } ssds_fault_t;

  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
  } ssds_lamp_t;

  typedef enum logic [2:0] {
    SSDS_RUN     = 3'b000,
    SSDS_WARN    = 3'b001,
    SSDS_ERROR   = 3'b010,
    SSDS_LOCK    = 3'b011,
    SSDS_TEACH   = 3'b100,
    SSDS_RELEASE = 3'b101
  } ssds_state_t;

  typedef enum logic [1:0] {
    SSDS_FL_IDLE  = 2'b00,
    SSDS_FL_ON    = 2'b01,
    SSDS_FL_OFF   = 2'b10,
    SSDS_FL_PAUSE = 2'b11
  } ssds_flash_t;
endpackage

// *** logic/ssds_supervisor.sv ***
// fault supervision, lamp codes and serial diagnostic bytes of the switch
// Contract
// - green supply, yellow condition, red faults
// - open guard: outputs low; closed: high
// - internal error switches outputs off immediately
// - warning: red flashes, diag low, 30min
// - warning clears itself when cause gone
// - plain variant: error clears on cause gone+open
// - codes 1..4 are delayed warnings
// - codes 5,6 and steady red: immediate off
// - output fault: self-test fail or voltage
// - teach-in: green off, red on, yellow flash
// - release block: green flashes, rest off
// - serial chain, at most 31 switches
// - gateway loss keeps output state
// - serial reset: reset bit falls or open
// - output faults clear at next enable
// - two output faults lock until power cycle
// - response byte bit layout
// - warning detail byte bit layout
// - error detail byte bit layout
// - all flags active high
// - detail bytes readable on error/warning
// - bytes offered continuously, one request each
// - teach-in yellow flashes at 1 Hz
`timescale 1ns/100ps
`default_nettype none
module ssds_supervisor #(
  parameter longint unsigned WARN_CYCLES = ssds_pkg::WARN_CYC
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_sys_rst,
  // variant straps and pin inputs
  input  wire logic                  i_serial_variant,
  input  wire logic                  i_guard_closed,
  input  wire logic                  i_safe_in_a,
  input  wire logic                  i_safe_in_b,
  input  wire logic                  i_actuator_present,
  input  wire logic                  i_coding_ok,
  input  wire logic                  i_teach_active,
  input  wire logic                  i_release_block,
  input  wire ssds_pkg::ssds_fault_t i_fault,
  // serial diagnostic link
  input  wire logic [7:0]            i_host_request_byte,
  input  wire logic                  i_host_request_valid,
  input  wire logic                  i_comm_fault,
  output logic [7:0]                 o_switch_response_byte,
  output logic [7:0]                 o_warning_detail_byte,
  output logic [7:0]                 o_error_detail_byte,
  output logic                       o_detail_valid,
  // outputs and lamps
  output logic                       o_safe_out_a,
  output logic                       o_safe_out_b,
  output logic                       o_diag_out,
  output ssds_pkg::ssds_lamp_t       o_lamp
);

  // two-flop synchronisers for all asynchronous pins
  localparam int unsigned NSYNC = 9 + 9;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  assign pin_raw = {i_serial_variant, i_guard_closed, i_safe_in_a,
                    i_safe_in_b, i_actuator_present, i_coding_ok,
                    i_teach_active, i_release_block, i_comm_fault,
                    i_fault};
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  ssds_pkg::ssds_fault_t flt;
  logic serial_v, guard, in_a, in_b, act_det, coding, teach, release_blk;
  logic comm_f;
  assign {serial_v, guard, in_a, in_b, act_det, coding, teach, release_blk,
          comm_f} = sync2_reg[NSYNC-1:9];
  assign flt = sync2_reg[8:0];

  // fault classes
  logic out_a_f, out_b_f, warn_cause, err_cause, multi_out;
  assign out_a_f    = flt.out_a_test_fail | flt.out_a_volt_off;
  assign out_b_f    = flt.out_b_test_fail | flt.out_b_volt_off;
  assign warn_cause = out_a_f | out_b_f | flt.cross_short
                    | flt.over_temp;
  assign err_cause  = flt.actuator_fault | flt.handle_fault
                    | flt.internal_fault;
  assign multi_out  = out_a_f & out_b_f;

  // latched output faults survive until the next enable
  logic out_a_lat_reg, out_b_lat_reg;
  logic out_en;

  // reset bit falling edge on an accepted request
  logic req_bit_reg;
  logic reset_fall;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      req_bit_reg <= 1'b0;
    end else if (i_host_request_valid) begin
      req_bit_reg <= i_host_request_byte[ssds_pkg::REQ_RESET_BIT];
    end
  end
  assign reset_fall = serial_v & i_host_request_valid & req_bit_reg
                    & ~i_host_request_byte[ssds_pkg::REQ_RESET_BIT];

  // warning delay counter
  logic [42:0] warn_cnt_reg;
  logic        warn_expired;
  assign warn_expired = (64'(warn_cnt_reg) >= WARN_CYCLES - 64'd1);

  ssds_pkg::ssds_state_t state_reg, state_next;
  logic                  err_clear;
  logic                  cause_gone;
  assign cause_gone = ~err_cause & ~warn_cause & ~out_a_lat_reg
                    & ~out_b_lat_reg;
  // error clears on guard open, or serial reset bit falling
  assign err_clear = cause_gone & (~guard | reset_fall);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ssds_pkg::SSDS_RUN: begin
        if (err_cause) begin
          state_next = ssds_pkg::SSDS_ERROR;
        end else if (warn_cause) begin
          state_next = ssds_pkg::SSDS_WARN;
        end
      end
      ssds_pkg::SSDS_WARN: begin
        if (err_cause) begin
          state_next = ssds_pkg::SSDS_ERROR;
        end else if (!warn_cause) begin
          state_next = ssds_pkg::SSDS_RUN;
        end else if (warn_expired) begin
          state_next = ssds_pkg::SSDS_ERROR;
        end
      end
      ssds_pkg::SSDS_ERROR: begin
        if (err_clear) begin
          state_next = ssds_pkg::SSDS_RUN;
        end
      end
      ssds_pkg::SSDS_LOCK: begin
        state_next = ssds_pkg::SSDS_LOCK;
      end
      ssds_pkg::SSDS_TEACH: begin
        if (!teach) begin
          state_next = ssds_pkg::SSDS_RUN;
        end
      end
      ssds_pkg::SSDS_RELEASE: begin
        if (!release_blk) begin
          state_next = ssds_pkg::SSDS_RUN;
        end
      end
      default: state_next = ssds_pkg::SSDS_RUN;
    endcase
    if (multi_out && state_reg != ssds_pkg::SSDS_LOCK) begin
      state_next = ssds_pkg::SSDS_LOCK;
    end else if (teach && state_reg != ssds_pkg::SSDS_LOCK) begin
      state_next = ssds_pkg::SSDS_TEACH;
    end else if (release_blk && state_reg != ssds_pkg::SSDS_LOCK) begin
      state_next = ssds_pkg::SSDS_RELEASE;
    end
  end

  // gateway loss never moves the output state: comm_f only reported
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= ssds_pkg::SSDS_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || state_reg != ssds_pkg::SSDS_WARN) begin
      warn_cnt_reg <= '0;
    end else if (!warn_expired) begin
      warn_cnt_reg <= warn_cnt_reg + 43'h1;
    end
  end

  // outputs enabled only in run and warning with guard closed
  logic out_en_next;
  assign out_en_next = guard & in_a & in_b
                     & (state_reg == ssds_pkg::SSDS_RUN
                        | state_reg == ssds_pkg::SSDS_WARN);
  logic out_en_reg;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      out_en_reg <= 1'b0;
    end else begin
      out_en_reg <= out_en_next;
    end
  end
  assign out_en = out_en_reg;

  // output faults latched; cleared only on a rising enable
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      out_a_lat_reg <= 1'b0;
      out_b_lat_reg <= 1'b0;
    end else begin
      if (out_a_f) begin
        out_a_lat_reg <= 1'b1;
      end else if (out_en_next && !out_en_reg) begin
        out_a_lat_reg <= 1'b0;
      end
      if (out_b_f) begin
        out_b_lat_reg <= 1'b1;
      end else if (out_en_next && !out_en_reg) begin
        out_b_lat_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_safe_out_a <= 1'b0;
      o_safe_out_b <= 1'b0;
      o_diag_out   <= 1'b0;
    end else begin
      o_safe_out_a <= out_en_next;
      o_safe_out_b <= out_en_next;
      o_diag_out   <= out_en_next & ~serial_v
                    & (state_reg == ssds_pkg::SSDS_RUN);
    end
  end

  // 1 Hz blink and flash code sequencer
  logic [27:0] blink_cnt_reg;
  logic        blink_reg;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg == 28'(ssds_pkg::HALF_1HZ_CYC - 1)) begin
      blink_cnt_reg <= '0;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 28'h1;
    end
  end

  logic [2:0] code;
  always_comb begin
    if (flt.handle_fault) begin
      code = ssds_pkg::CODE_HANDLE;
    end else if (flt.actuator_fault) begin
      code = ssds_pkg::CODE_ACT;
    end else if (flt.cross_short || multi_out) begin
      code = ssds_pkg::CODE_CROSS;
    end else if (flt.over_temp) begin
      code = ssds_pkg::CODE_TEMP;
    end else if (out_a_f || out_a_lat_reg) begin
      code = ssds_pkg::CODE_OUT_A;
    end else if (out_b_f || out_b_lat_reg) begin
      code = ssds_pkg::CODE_OUT_B;
    end else begin
      code = ssds_pkg::CODE_NONE;
    end
  end

  ssds_pkg::ssds_flash_t fl_reg;
  logic [25:0]           fl_tmr_reg;
  logic [2:0]            fl_cnt_reg;
  logic [2:0]            fl_code_reg;
  logic                  fl_tick;
  assign fl_tick = (fl_tmr_reg == 26'(ssds_pkg::PULSE_CYC - 1));
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      fl_reg      <= ssds_pkg::SSDS_FL_IDLE;
      fl_tmr_reg  <= '0;
      fl_cnt_reg  <= '0;
      fl_code_reg <= ssds_pkg::CODE_NONE;
    end else begin
      fl_tmr_reg <= fl_tick ? 26'h0 : fl_tmr_reg + 26'h1;
      case (fl_reg)
        ssds_pkg::SSDS_FL_IDLE: begin
          if (code != ssds_pkg::CODE_NONE && fl_tick) begin
            fl_code_reg <= code;
            fl_cnt_reg  <= 3'h1;
            fl_reg      <= ssds_pkg::SSDS_FL_ON;
          end
        end
        ssds_pkg::SSDS_FL_ON: begin
          if (fl_tick) begin
            fl_reg <= ssds_pkg::SSDS_FL_OFF;
          end
        end
        ssds_pkg::SSDS_FL_OFF: begin
          if (fl_tick) begin
            if (fl_cnt_reg == fl_code_reg) begin
              fl_cnt_reg <= '0;
              fl_reg     <= ssds_pkg::SSDS_FL_PAUSE;
            end else begin
              fl_cnt_reg <= fl_cnt_reg + 3'h1;
              fl_reg     <= ssds_pkg::SSDS_FL_ON;
            end
          end
        end
        ssds_pkg::SSDS_FL_PAUSE: begin
          if (fl_tick) begin
            if (fl_cnt_reg == 3'(ssds_pkg::PAUSE_PULSES - 1)) begin
              fl_cnt_reg <= '0;
              fl_reg     <= ssds_pkg::SSDS_FL_IDLE;
            end else begin
              fl_cnt_reg <= fl_cnt_reg + 3'h1;
            end
          end
        end
        default: fl_reg <= ssds_pkg::SSDS_FL_IDLE;
      endcase
    end
  end

  // lamps
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_lamp <= '0;
    end else begin
      o_lamp.green  <= 1'b1;
      o_lamp.yellow <= out_en_next
                     & (state_reg == ssds_pkg::SSDS_RUN);
      o_lamp.red    <= (fl_reg == ssds_pkg::SSDS_FL_ON);
      case (state_reg)
        ssds_pkg::SSDS_TEACH: begin
          o_lamp.green  <= 1'b0;
          o_lamp.red    <= 1'b1;
          o_lamp.yellow <= blink_reg;
        end
        ssds_pkg::SSDS_RELEASE: begin
          o_lamp.green  <= blink_reg;
          o_lamp.red    <= 1'b0;
          o_lamp.yellow <= 1'b0;
        end
        ssds_pkg::SSDS_ERROR, ssds_pkg::SSDS_LOCK: begin
          if (flt.internal_fault) begin
            o_lamp.red <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // serial diagnostic bytes, refreshed every cycle, flags active high
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_switch_response_byte <= '0;
      o_warning_detail_byte  <= '0;
      o_error_detail_byte    <= '0;
      o_detail_valid         <= 1'b0;
    end else begin
      o_switch_response_byte <= '0;
      o_switch_response_byte[ssds_pkg::RSP_OUT_ACT] <= out_en;
      o_switch_response_byte[ssds_pkg::RSP_ACT_DET] <= act_det;
      o_switch_response_byte[ssds_pkg::RSP_INPUTS]  <= in_a & in_b;
      o_switch_response_byte[ssds_pkg::RSP_CODING]  <= coding;
      o_switch_response_byte[ssds_pkg::RSP_WARN]    <=
        (state_reg == ssds_pkg::SSDS_WARN);
      o_switch_response_byte[ssds_pkg::RSP_ERROR]   <=
        (state_reg == ssds_pkg::SSDS_ERROR)
        | (state_reg == ssds_pkg::SSDS_LOCK);
      o_warning_detail_byte <= '0;
      o_warning_detail_byte[ssds_pkg::DET_OUT_A]  <= out_a_f;
      o_warning_detail_byte[ssds_pkg::DET_OUT_B]  <= out_b_f;
      o_warning_detail_byte[ssds_pkg::DET_CROSS]  <= flt.cross_short;
      o_warning_detail_byte[ssds_pkg::DET_TEMP]   <= flt.over_temp;
      o_warning_detail_byte[ssds_pkg::DET_INT]    <= flt.internal_fault;
      o_warning_detail_byte[ssds_pkg::DET_COMM]   <= comm_f;
      o_warning_detail_byte[ssds_pkg::DET_HANDLE] <= flt.handle_fault;
      o_error_detail_byte <= '0;
      o_error_detail_byte[ssds_pkg::DET_OUT_A]  <= out_a_lat_reg;
      o_error_detail_byte[ssds_pkg::DET_OUT_B]  <= out_b_lat_reg;
      o_error_detail_byte[ssds_pkg::DET_CROSS]  <= flt.cross_short;
      o_error_detail_byte[ssds_pkg::DET_TEMP]   <= flt.over_temp;
      o_error_detail_byte[ssds_pkg::DET_ACT]    <= flt.actuator_fault;
      o_error_detail_byte[ssds_pkg::DET_INT]    <= flt.internal_fault;
      o_error_detail_byte[ssds_pkg::DET_HANDLE] <= flt.handle_fault;
      o_detail_valid <= (state_reg != ssds_pkg::SSDS_RUN)
                      & (state_reg != ssds_pkg::SSDS_TEACH)
                      & (state_reg != ssds_pkg::SSDS_RELEASE);
    end
  end

endmodule
`default_nettype wire

// *** test/ssds_gateway_model.sv ***
// gateway stand-in: sends request bytes, collects the switch's bytes
`timescale 1ns/100ps
`default_nettype none
module ssds_gateway_model (
  // clock
  input  wire logic       i_clk,
  // from the switch
  input  wire logic [7:0] i_rsp,
  input  wire logic [7:0] i_err,
  // to the switch
  output logic [7:0]      o_req,
  output logic            o_req_valid,
  output logic            o_comm_fault
);
  logic [7:0] seen_rsp;
  logic [7:0] seen_err;
  initial begin
    o_req = 8'h7f;
    o_req_valid = 1'b0;
    o_comm_fault = 1'b0;
  end
  // one slot of the chain, read every cycle
  always @(posedge i_clk) begin
    seen_rsp <= i_rsp;
    if (i_rsp[7]) seen_err <= i_err;
  end
  // one byte per valid cycle; an idle byte shows its inverse
  task automatic send(input logic [7:0] b);
    @(posedge i_clk);
    #1;
    o_req = b;
    o_req_valid = 1'b1;
    @(posedge i_clk);
    #1;
    o_req = ~b;
    o_req_valid = 1'b0;
  endtask
  task automatic link_loss(input logic f);
    @(posedge i_clk);
    #1;
    o_comm_fault = f;
  endtask
endmodule
`default_nettype wire

// *** test/ssds_supervisor_sva.sv ***
// port assertions for the switch supervisor
`timescale 1ns/100ps
`default_nettype none
module ssds_supervisor_sva #(
  parameter longint unsigned WARN_CYCLES = ssds_pkg::WARN_CYC
) (
  // clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_sys_rst,
  // pins
  input wire logic                  i_serial_variant,
  input wire logic                  i_guard_closed,
  input wire logic                  i_teach_active,
  input wire ssds_pkg::ssds_fault_t i_fault,
  // results
  input wire logic [7:0]            o_switch_response_byte,
  input wire logic                  o_detail_valid,
  input wire logic                  o_safe_out_a,
  input wire logic                  o_safe_out_b,
  input wire logic                  o_diag_out,
  input wire ssds_pkg::ssds_lamp_t  o_lamp
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  // cycles of the running warning with outputs still on
  longint unsigned warn_run;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || !o_switch_response_byte[6] || !o_safe_out_a) begin
      warn_run <= '0;
    end else begin
      warn_run <= warn_run + 1;
    end
  end
  sequence s_open_held;
    !i_guard_closed [*5];
  endsequence
  sequence s_warn_start;
    $rose(o_switch_response_byte[6]) && o_safe_out_a;
  endsequence
  a_open_outputs_off: assert property (
    s_open_held |-> !o_safe_out_a && !o_safe_out_b)
    else $error("outputs on with guard open");
  a_internal_off: assert property (
    i_fault.internal_fault [*5] |-> !o_safe_out_a && !o_safe_out_b)
    else $error("outputs on during internal fault");
  a_serial_diag_low: assert property (
    i_serial_variant [*5] |-> !o_diag_out)
    else $error("diag output high in serial variant");
  a_diag_needs_run: assert property (
    o_diag_out |-> o_safe_out_a && o_safe_out_b && o_lamp.yellow)
    else $error("diag output high outside run");
  a_warn_diag_low: assert property (
    $rose(o_switch_response_byte[6]) |-> ##[0:1] !o_diag_out)
    else $error("diag output high in warning");
  a_warn_keeps_on: assert property (
    s_warn_start |-> o_safe_out_a [*8])
    else $error("warning dropped outputs early");
  a_warn_delay_bound: assert property (
    warn_run <= WARN_CYCLES + 64'd4)
    else $error("warning outlived its delay");
  a_detail_on_fault: assert property (
    $rose(o_switch_response_byte[6] | o_switch_response_byte[7])
      |-> ##[0:1] o_detail_valid)
    else $error("detail bytes not offered");
  a_teach_lamps: assert property (
    i_teach_active [*5] |-> !o_lamp.green && o_lamp.red
      && !o_safe_out_a && !o_diag_out)
    else $error("teach-in indication wrong");
endmodule
bind ssds_supervisor ssds_supervisor_sva #(.WARN_CYCLES(WARN_CYCLES)) u_sva (
  .i_clk, .i_sys_rst, .i_serial_variant, .i_guard_closed, .i_teach_active,
  .i_fault, .o_switch_response_byte, .o_detail_valid, .o_safe_out_a,
  .o_safe_out_b, .o_diag_out, .o_lamp);
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the switch supervisor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int WCYC = 50;
  logic                  i_clk, i_sys_rst, i_serial_variant, i_guard_closed;
  logic                  i_safe_in_a, i_safe_in_b, i_actuator_present;
  logic                  i_coding_ok, i_teach_active, i_release_block;
  logic                  i_host_request_valid, i_comm_fault, o_detail_valid;
  logic                  o_safe_out_a, o_safe_out_b, o_diag_out;
  logic [7:0]            i_host_request_byte, o_switch_response_byte;
  logic [7:0]            o_warning_detail_byte, o_error_detail_byte;
  ssds_pkg::ssds_fault_t i_fault;
  ssds_pkg::ssds_lamp_t  o_lamp;
  logic [31:0]           rng;
  logic [7:0]            err_bit [3];
  int                    error_cnt, check_count, m_on, m_warn, m_err;

  ssds_supervisor #(.WARN_CYCLES(WCYC)) u_dut (
    .i_clk, .i_sys_rst, .i_serial_variant, .i_guard_closed, .i_safe_in_a,
    .i_safe_in_b, .i_actuator_present, .i_coding_ok, .i_teach_active,
    .i_release_block, .i_fault, .i_host_request_byte, .i_host_request_valid,
    .i_comm_fault, .o_switch_response_byte, .o_warning_detail_byte,
    .o_error_detail_byte, .o_detail_valid, .o_safe_out_a, .o_safe_out_b,
    .o_diag_out, .o_lamp);
  ssds_gateway_model u_gw (
    .i_clk, .i_rsp(o_switch_response_byte), .i_err(o_error_detail_byte),
    .o_req(i_host_request_byte), .o_req_valid(i_host_request_valid),
    .o_comm_fault(i_comm_fault));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [7:0] rsp_exp();
    return {m_err != 0, m_warn != 0, i_coding_ok, i_safe_in_a && i_safe_in_b,
            2'h0, i_actuator_present, m_on != 0};
  endfunction
  task automatic cmp(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // compare outputs, diag, yellow, green and response bytes with the model after the pins settle
  task automatic check_all(input string tn);
    logic d;
    cyc(8);
    d = !i_serial_variant && m_on != 0 && m_warn == 0;
    cmp("safe_out_a", 8'(m_on), 8'(o_safe_out_a));
    cmp("safe_out_b", 8'(m_on), 8'(o_safe_out_b));
    cmp("diag_out", 8'(d), 8'(o_diag_out));
    cmp("yellow", 8'(m_on != 0 && m_warn == 0),
        8'(o_lamp.yellow));
    cmp("green", 8'h01, 8'(o_lamp.green));
    cmp("response", rsp_exp(), o_switch_response_byte);
    cmp("gw_response", rsp_exp(), u_gw.seen_rsp);
    $display("test %s done", tn);
  endtask
  task automatic guard_cycle();
    i_guard_closed = 1'b0;
    cyc(8);
    i_guard_closed = 1'b1;
  endtask
  task automatic pulse_reset();
    i_sys_rst = 1'b1;
    cyc(2);
    i_sys_rst = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    $display("watchdog expired");
    close_out();
  end
  initial begin
    err_bit = '{8'h10, 8'h80, 8'h20};
    rng = 32'h0000a6c3;
    {error_cnt, check_count, m_on, m_warn, m_err} = '0;
    {i_serial_variant, i_guard_closed, i_teach_active, i_release_block} = '0;
    {i_safe_in_a, i_safe_in_b, i_actuator_present, i_coding_ok} = 4'hf;
    i_fault = '0;
    i_sys_rst = 1'b1;
    cyc(2);
    i_sys_rst = 1'b0;
    check_all("guard_open");
    i_guard_closed = 1'b1;
    m_on = 1;
    check_all("guard_closed");
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      {i_safe_in_a, i_safe_in_b, i_actuator_present, i_coding_ok} = rng[11:8];
      m_on = i_safe_in_a && i_safe_in_b;
      u_gw.send({1'b0, rng[6:0]});
      check_all("plain_request");
    end
    {i_safe_in_a, i_safe_in_b, i_actuator_present, i_coding_ok} = 4'hf;
    m_on = 1;
    i_fault.over_temp = 1'b1;
    m_warn = 1;
    check_all("warning");
    cmp("warn_detail", 8'h08, o_warning_detail_byte);
    cmp("detail_valid", 8'h01, 8'(o_detail_valid));
    cyc(WCYC - 20);
    check_all("warning_held");
    i_fault.over_temp = 1'b0;
    m_warn = 0;
    check_all("warning_cleared");
    i_fault.cross_short = 1'b1;
    m_warn = 1;
    check_all("long_warning");
    cyc(WCYC);
    cmp("safe_out_a", 8'h00, 8'(o_safe_out_a));
    cmp("error_flag", 8'h01, 8'(o_switch_response_byte[7]));
    cmp("error_detail", 8'h04, o_error_detail_byte & 8'h04);
    i_fault = '0;
    m_warn = 0;
    guard_cycle();
    check_all("error_cleared");
    for (int k = 0; k < 3; k++) begin
      i_fault.actuator_fault = (k == 0);
      i_fault.handle_fault = (k == 1);
      i_fault.internal_fault = (k == 2);
      m_on = 0;
      m_err = 1;
      check_all("immediate_error");
      cmp("error_detail", err_bit[k], o_error_detail_byte);
      cmp("gw_error", err_bit[k], u_gw.seen_err);
      if (k == 2) cmp("red", 8'h01, 8'(o_lamp.red));
      i_fault = '0;
      guard_cycle();
      m_on = 1;
      m_err = 0;
      check_all("error_reset");
    end
    u_gw.link_loss(1'b1);
    check_all("link_loss");
    cmp("warn_detail", 8'h40, o_warning_detail_byte);
    u_gw.link_loss(1'b0);
    i_serial_variant = 1'b1;
    pulse_reset();
    check_all("serial_run");
    i_fault.actuator_fault = 1'b1;
    m_on = 0;
    m_err = 1;
    check_all("serial_error");
    i_fault = '0;
    u_gw.send(8'h80);
    check_all("reset_bit_high");
    u_gw.send(8'h00);
    m_on = 1;
    m_err = 0;
    check_all("serial_reset");
    i_teach_active = 1'b1;
    cyc(8);
    cmp("teach_lamps", 8'h01, 8'({o_lamp.green, o_lamp.red}));
    cmp("teach_outs", 8'h00, 8'({o_safe_out_a, o_safe_out_b}));
    i_teach_active = 1'b0;
    i_release_block = 1'b1;
    cyc(8);
    cmp("release_lamps", 8'h00,
        8'({o_lamp.yellow, o_lamp.red}));
    cmp("release_outs", 8'h00,
        8'({o_safe_out_a, o_safe_out_b}));
    i_release_block = 1'b0;
    check_all("after_release");
    i_fault.out_a_volt_off = 1'b1;
    m_warn = 1;
    check_all("output_a_fault");
    cmp("warn_detail", 8'h01, o_warning_detail_byte);
    cyc(4);
    i_fault.out_b_test_fail = 1'b1;
    {m_on, m_warn, m_err} = {32'd0, 32'd0, 32'd1};
    check_all("lockout");
    cmp("error_detail", 8'h03, o_error_detail_byte & 8'h03);
    i_fault = '0;
    guard_cycle();
    u_gw.send(8'h80);
    u_gw.send(8'h00);
    check_all("lock_held");
    pulse_reset();
    m_on = 1;
    m_err = 0;
    check_all("power_cycle");
    cmp("error_detail", 8'h00, o_error_detail_byte);
    close_out();
  end
endmodule
`default_nettype wire
